/* File: hw/fsp_page_buffer.sv */
`include "fsp_consts.svh"

// Temporary page buffer: one word per position, cleared as a whole
module fsp_page_buffer
    import fsp_pkg::*;
#(
    parameter int WORDS = 32,
    parameter int IDX_W = 5
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control
    input wire logic clear,
    input wire logic load,
    input wire logic [IDX_W-1:0] load_idx,
    input wire logic [15:0] load_data,
    // Read port
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [15:0] rd_data
);

    logic [15:0] mem_q [WORDS];

    // Each entry loads on its own index; clear wins because the buffer
    // is discarded at the same moment it would be filled
    genvar g;
    generate
        for (g = 0; g < WORDS; g++)
        begin : g_word
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    mem_q[g] <= 16'hFFFF;
                else if (clear)
                    mem_q[g] <= 16'hFFFF;
                else if (load && load_idx == IDX_W'(g))
                    mem_q[g] <= load_data;
            end
        end
    endgenerate

    assign rd_data = mem_q[rd_idx];

endmodule : fsp_page_buffer

/* File: hw/fsp_sequencer.sv */
// Contract
// - Fuse one boots application, zero boots loader
// - Software can never change fuses
// - Address comes from high/low pointer pair
// - Low bits word, high bits page
// - Capture target address when operation starts
// - Lock command ignores pointer pair
// - Byte reads use pointer bit zero
// - Buffer words load singly in any order
// - Erase pattern then store within four cycles
// - Halting section halts CPU; other allows fetch
// - Buffer load stores word at word index
// - Buffer clears on write, re-enable, reset
// - EEPROM write while loading discards buffer
// - Page write pattern, page only, data ignored
// - Level interrupt while enabled and enable clear
// - Busy flag and read block during programming
// - Re-enable clears busy and unblocks reads
// - Lock write programs zero bits of R0
// - Lock programming never blocks reads
// - Pending command clears after four cycles
// - Each operation lasts 3.2 to 3.4 ms
// - Refuse commands during EEPROM write
`include "fsp_consts.svh"

module fsp_sequencer
    import fsp_pkg::*;
#(
    parameter int PAGE_WORDS = 32,
    parameter int WORD_IDX_W = 5,
    parameter logic [15:0] LOADER_RESET_ADDR = 16'h3800,
    parameter logic [15:0] HALT_SECTION_START = 16'h3800,
    parameter int PROG_CYCLES = ((`FSP_PROG_MIN_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Fuse (read only here)
    input wire logic boot_vector_fuse,
    output logic [15:0] reset_vector,
    // Control register access from the core
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    output logic [7:0] self_prog_ctrl_status,
    // Pointer pair and data pair
    input wire logic [7:0] pointer_high_byte,
    input wire logic [7:0] pointer_low_byte,
    input wire logic [15:0] data_pair,
    // Store-program instruction
    input wire logic store_exec,
    // Load-program byte read
    input wire logic [15:0] flash_rd_word,
    output logic [15:0] flash_rd_addr,
    output logic [7:0] load_byte,
    // Section gating
    input wire logic fetch_in_concurrent,
    output logic concurrent_read_block,
    output logic cpu_halt,
    // EEPROM status
    input wire logic eeprom_busy,
    input wire logic eeprom_write_start,
    // Interrupt
    input wire logic irq_enable,
    output logic irq,
    // Flash array interface
    output fsp_flash_req_t flash_req,
    output logic [15:0] flash_wdata,
    output logic [5:0] lock_bits
);

    localparam int CNT_W = $clog2(PROG_CYCLES + 1);
    localparam int PAGE_LSB = WORD_IDX_W + 1;

    fsp_state_t state_q;
    fsp_op_t op_q;
    logic [6:0] ctrl_q;
    logic busy_q;
    logic halt_q;
    logic [2:0] arm_cnt_q;
    logic [CNT_W-1:0] prog_cnt_q;
    logic [15:0] addr_q;
    logic [5:0] lock_q;
    logic loading_q;
    logic [WORD_IDX_W-1:0] wr_idx_q;
    logic [15:0] buf_rd;
    logic [15:0] ptr;
    logic store_go;
    logic prog_done;
    logic buf_load;
    logic buf_clear;
    logic reen_wr;
    logic [5:0] lock_pend_q;
    // Decoded command
    fsp_op_t cmd_op;
    logic cmd_load;

    // Pointer pair forms the flash address
    assign ptr = {pointer_high_byte, pointer_low_byte};

    // Fuse is only sampled, never written by this block
    assign reset_vector = boot_vector_fuse ? `FSP_APP_RESET_ADDR : LOADER_RESET_ADDR;

    // A store arrives while a command is armed and EEPROM idle
    assign store_go = (state_q == FSP_ARMED) && store_exec && !eeprom_busy;
    assign prog_done = (state_q == FSP_PROG) && (prog_cnt_q == CNT_W'(PROG_CYCLES - 1));
    assign buf_load = store_go && cmd_load;
    assign reen_wr = ctrl_wr && ctrl_wdata[`FSP_BIT_REEN] && ctrl_wdata[`FSP_BIT_ENABLE]
        && state_q != FSP_PROG && !eeprom_busy;
    // Buffer clears after write, on re-enable, or EEPROM write during loading
    assign buf_clear = (prog_done && op_q == FSP_OP_WRITE) || reen_wr
        || (eeprom_write_start && loading_q);

    // Decode the armed pattern once so that state, operation and busy agree;
    // a pattern with more than one select starts nothing
    always_comb
    begin
        cmd_op = FSP_OP_NONE;
        cmd_load = 1'b0;
        case ({1'b0, ctrl_q})
            {1'b0, `FSP_CMD_ERASE}:
                cmd_op = FSP_OP_ERASE;
            {1'b0, `FSP_CMD_WRITE}:
                cmd_op = FSP_OP_WRITE;
            {1'b0, `FSP_CMD_LOCK}:
                cmd_op = FSP_OP_LOCK;
            `FSP_CMD_LOAD:
                cmd_load = 1'b1;
            default:
                cmd_op = FSP_OP_NONE;
        endcase
    end

    // Command arming and four-cycle window
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= FSP_IDLE;
            ctrl_q <= 7'h00;
            arm_cnt_q <= 3'h0;
        end
        else
        begin
            case (state_q)
                FSP_IDLE:
                begin
                    // Writes refused while EEPROM is programming
                    if (ctrl_wr && ctrl_wdata[`FSP_BIT_ENABLE] && !eeprom_busy && !reen_wr)
                    begin
                        state_q <= FSP_ARMED;
                        ctrl_q <= {2'b00, ctrl_wdata[4:0]};
                        arm_cnt_q <= 3'h0;
                    end
                end
                FSP_ARMED:
                begin
                    if (store_go)
                    begin
                        if (cmd_op != FSP_OP_NONE)
                            state_q <= FSP_PROG;
                        else
                        begin
                            state_q <= FSP_IDLE;
                            ctrl_q <= 7'h00;
                        end
                    end
                    else if (arm_cnt_q == 3'(`FSP_ARM_CYCLES - 1))
                    begin
                        // No store in time: drop enable and selects
                        state_q <= FSP_IDLE;
                        ctrl_q <= 7'h00;
                    end
                    else
                        arm_cnt_q <= arm_cnt_q + 3'h1;
                end
                FSP_PROG:
                begin
                    if (prog_done)
                    begin
                        state_q <= FSP_IDLE;
                        ctrl_q <= 7'h00;
                    end
                end
                default:
                    state_q <= FSP_IDLE;
            endcase
        end
    end

    // Operation kind, captured address and lock data
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            op_q <= FSP_OP_NONE;
            addr_q <= 16'h0000;
            lock_pend_q <= `FSP_LOCK_RESET;
        end
        else if (store_go)
        begin
            op_q <= cmd_op;
            case (cmd_op)
                FSP_OP_ERASE:
                    // Only the page field matters for erase
                    addr_q <= {ptr[15:PAGE_LSB], {PAGE_LSB{1'b0}}};
                FSP_OP_WRITE:
                    addr_q <= {ptr[15:PAGE_LSB], {PAGE_LSB{1'b0}}};
                FSP_OP_LOCK:
                    // Pointer left untouched; only the low six data bits are kept
                    lock_pend_q <= data_pair[5:0];
                default:
                    addr_q <= addr_q;
            endcase
        end
        else if (prog_done)
            op_q <= FSP_OP_NONE;
    end

    // Lock cells change only once the write time has run out;
    // a zero data bit programs its cell, a one leaves it as it was
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            lock_q <= `FSP_LOCK_RESET;
        else if (prog_done && op_q == FSP_OP_LOCK)
            lock_q <= lock_q & lock_pend_q;
    end

    // Programming timer, rounded up from the least time
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            prog_cnt_q <= '0;
        else if (state_q != FSP_PROG)
            prog_cnt_q <= '0;
        else
            prog_cnt_q <= prog_cnt_q + CNT_W'(1);
    end

    // Busy flag and CPU halt; lock programming blocks nothing
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy_q <= 1'b0;
            halt_q <= 1'b0;
        end
        else
        begin
            if (store_go && (cmd_op == FSP_OP_ERASE || cmd_op == FSP_OP_WRITE))
            begin
                busy_q <= 1'b1;
                halt_q <= (ptr >= HALT_SECTION_START);
            end
            else
            begin
                if (prog_done)
                    halt_q <= 1'b0;
                // Clearing only once the operation is over; set wins
                if (reen_wr)
                    busy_q <= 1'b0;
            end
        end
    end

    // Tracks whether page loading is under way
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            loading_q <= 1'b0;
        else if (buf_load)
            loading_q <= 1'b1;
        else if (buf_clear)
            loading_q <= 1'b0;
    end

    // Page write streams the buffer; index walks with the timer
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wr_idx_q <= '0;
        else if (state_q == FSP_PROG && op_q == FSP_OP_WRITE)
            wr_idx_q <= wr_idx_q + WORD_IDX_W'(1);
        else
            wr_idx_q <= '0;
    end

    fsp_page_buffer #(
        .WORDS(PAGE_WORDS),
        .IDX_W(WORD_IDX_W)
    ) u_buf (
        .clk(clk),
        .arst_n(arst_n),
        .clear(buf_clear),
        .load(buf_load),
        .load_idx(ptr[WORD_IDX_W:1]),
        .load_data(data_pair),
        .rd_idx(wr_idx_q),
        .rd_data(buf_rd)
    );

    // Flash request outputs come from flops
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flash_req <= '0;
            flash_wdata <= 16'hFFFF;
        end
        else
        begin
            flash_req.erase <= (state_q == FSP_PROG) && (op_q == FSP_OP_ERASE);
            flash_req.write <= (state_q == FSP_PROG) && (op_q == FSP_OP_WRITE);
            flash_req.lock <= (state_q == FSP_PROG) && (op_q == FSP_OP_LOCK);
            flash_req.addr <= {addr_q[15:PAGE_LSB], wr_idx_q, 1'b0};
            flash_wdata <= buf_rd;
        end
    end

    // Byte read: Z0 picks the byte within the word
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            load_byte <= 8'h00;
        else
            load_byte <= ptr[0] ? flash_rd_word[15:8] : flash_rd_word[7:0];
    end

    assign flash_rd_addr = {ptr[15:1], 1'b0};
    assign lock_bits = lock_q;
    assign self_prog_ctrl_status = {1'b0, busy_q, 1'b0, ctrl_q[4:0]};
    // Reads of the concurrent section are blocked while busy
    assign concurrent_read_block = busy_q && fetch_in_concurrent;
    assign cpu_halt = halt_q;
    assign irq = irq_enable && !ctrl_q[`FSP_BIT_ENABLE];

endmodule : fsp_sequencer

/* File: pkg/fsp_consts.svh */
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// Control register bit positions
`define FSP_BIT_ENABLE 0
`define FSP_BIT_ERASE 1
`define FSP_BIT_WRITE 2
`define FSP_BIT_LOCK 3
`define FSP_BIT_REEN 4
`define FSP_BIT_BUSY 6

// Command patterns (bit 7 is don't care where printed as X)
`define FSP_CMD_ERASE 7'h03
`define FSP_CMD_WRITE 7'h05
`define FSP_CMD_LOCK 7'h09
`define FSP_CMD_LOAD 8'h01

// Store instruction must follow the control write within this many cycles
`define FSP_ARM_CYCLES 4

// Application reset address
`define FSP_APP_RESET_ADDR 16'h0000

// Programming time, nanoseconds; clock period in nanoseconds
`define FSP_PROG_MIN_NS 3200000
`define FSP_PROG_MAX_NS 3400000
`define FSP_CLK_NS 8

// Lock bits unprogrammed value
`define FSP_LOCK_RESET 6'h3F

`endif

/* File: pkg/fsp_pkg.sv */
package fsp_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        FSP_IDLE,
        FSP_ARMED,
        FSP_PROG
    } fsp_state_t;

    // Kind of long operation in progress
    typedef enum logic [1:0] {
        FSP_OP_NONE,
        FSP_OP_ERASE,
        FSP_OP_WRITE,
        FSP_OP_LOCK
    } fsp_op_t;

    // Store-program request from the core
    typedef struct packed {
        logic [15:0] ptr;
        logic [15:0] data;
    } fsp_store_t;

    // Request to the flash array macro
    typedef struct packed {
        logic erase;
        logic write;
        logic lock;
        logic [15:0] addr;
    } fsp_flash_req_t;

endpackage : fsp_pkg

/* File: tb/flash_self_programming_test.sv */
module flash_self_programming_test
    import fsp_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PROG = 20;
    localparam logic [15:0] LOADER = 16'h3800;
    logic clk, arst_n, fuse, fetch, eep_busy, irq_en, ctrl_wr, store_exec, block, halt, irq, ews;
    logic [7:0] zh, zl, wdata, st, lbyte;
    logic [15:0] r10, vec, raddr, wd;
    logic [5:0] locks;
    fsp_flash_req_t req;
    int err_count, samples_checked;

    // Short programming time keeps the run brief
    fsp_sequencer #(.PROG_CYCLES(PROG), .LOADER_RESET_ADDR(LOADER)) fsp_sequencer_inst (
        .clk(clk), .arst_n(arst_n), .boot_vector_fuse(fuse), .reset_vector(vec), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(wdata), .self_prog_ctrl_status(st), .pointer_high_byte(zh), .pointer_low_byte(zl),
        .data_pair(r10), .store_exec(store_exec), .flash_rd_word(16'hC35A), .flash_rd_addr(raddr), .load_byte(lbyte),
        .fetch_in_concurrent(fetch), .concurrent_read_block(block), .cpu_halt(halt), .eeprom_busy(eep_busy),
        .eeprom_write_start(ews), .irq_enable(irq_en), .irq(irq), .flash_req(req), .flash_wdata(wd),
        .lock_bits(locks)
    );
    fsp_core_model fsp_core_model_inst (.clk(clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(wdata), .store_exec(store_exec));

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run();
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    // Start a long command, return one cycle after the array request rises
    task automatic launch(input logic [7:0] c);
        int w;
        w = 0;
        fsp_core_model_inst.spm(c, 2);
        while (!(req.erase || req.write || req.lock) && w < 20)
        begin
            tick();
            w++;
        end
        tick();
    endtask : launch

    // Count the rest of the operation from the cycles already spent, then re-enable reads
    task automatic finish(input int start);
        int n;
        n = start;
        while ((req.erase || req.write || req.lock) && n < 50)
        begin
            tick();
            n++;
        end
        chk(16'(n >= PROG && n <= PROG + 1), 16'h0001);
        repeat (2) tick();
        chk(16'(irq), 16'h0001);
        fsp_core_model_inst.spm(8'h11, 2);
        repeat (2) tick();
        chk({14'h0000, st[6], block}, 16'h0000);
    endtask : finish

    // Vector by fuse, read address from the pointer, byte pick by pointer bit zero
    task automatic t_reset();
        chk(vec, 16'h0000);
        chk({10'h000, locks}, 16'h003F);
        chk({st, 7'h00, irq}, 16'h0001);
        fuse = 1'b0;
        zh = 8'h12;
        zl = 8'h35;
        repeat (2) tick();
        chk(vec, LOADER);
        chk(raddr, 16'h1234);
        chk({8'h00, lbyte}, 16'h00C3);
        zl = 8'h34;
        repeat (2) tick();
        chk({8'h00, lbyte}, 16'h005A);
        zh = 8'h00;
        zl = 8'h00;
        fuse = 1'b1;
    endtask : t_reset

    // Refused while the data EEPROM writes
    task automatic t_eep();
        eep_busy = 1'b1;
        fsp_core_model_inst.spm(8'h03, 2);
        repeat (3) tick();
        chk({11'h000, st[4:0]}, 16'h0000);
        chk(16'(req.erase), 16'h0000);
        eep_busy = 1'b0;
    endtask : t_eep

    // Unstored command lapses; a late store then does nothing
    task automatic t_stale();
        fsp_core_model_inst.spm(8'h05, 0);
        repeat (6) tick();
        chk({11'h000, st[4:0]}, 16'h0000);
        fsp_core_model_inst.spm(8'h00, 1);
        repeat (3) tick();
        chk({13'h0000, req.erase, req.write, req.lock}, 16'h0000);
    endtask : t_stale

    // Erase in the concurrent section; the pointer moves on a cycle before the look
    task automatic t_erase();
        zh = 8'h12;
        zl = 8'h7F;
        launch(8'h03);
        zh = 8'hFF;
        tick();
        chk(req.addr, 16'h1240);
        chk({13'h0000, st[6], block, halt}, 16'h0006);
        chk(16'(irq), 16'h0000);
        finish(2);
    endtask : t_erase

    // Page erased first; one word lost to an EEPROM write, two loaded out of order,
    // then a write that halts the core and streams the buffer
    task automatic t_write();
        zh = 8'h38;
        zl = 8'h40;
        launch(8'h03);
        chk(16'(halt), 16'h0001);
        finish(1);
        zl = 8'h4A;
        r10 = 16'hBEEF;
        fsp_core_model_inst.spm(8'h01, 2);
        ews = 1'b1;
        tick();
        ews = 1'b0;
        for (int i = 3; i > 0; i -= 2)
        begin
            zl = 8'(8'h40 + 2 * i);
            r10 = 16'(16'hA000 + i);
            fsp_core_model_inst.spm(8'h01, 2);
            repeat (2) tick();
            chk({11'h000, st[4:0]}, 16'h0000);
        end
        zl = 8'h40;
        launch(8'h05);
        chk({6'h00, req.addr[15:6]}, 16'h00E1);
        chk(16'(halt), 16'h0001);
        chk(wd, 16'hA001);
        repeat (2) tick();
        chk(wd, 16'hA003);
        repeat (2) tick();
        chk({10'h000, req.addr[5:0]}, 16'h000A);
        chk(wd, 16'hFFFF);
        finish(5);
    endtask : t_write

    // Lock bits from the data byte: advised pointer and top bits, then junk pointer
    task automatic t_lock();
        zh = 8'h00;
        zl = 8'h01;
        r10 = 16'h00FE;
        launch(8'h09);
        chk({14'h0000, block, halt}, 16'h0000);
        finish(1);
        chk({10'h000, locks}, 16'h003E);
        zh = 8'hAB;
        zl = 8'hCD;
        r10 = 16'h00F5;
        launch(8'h09);
        chk({13'h0000, st[6], block, halt}, 16'h0000);
        finish(1);
        chk({10'h000, locks}, 16'h0034);
    endtask : t_lock

    // Main sequence; lock runs last since programmed bits stay
    initial
    begin
        arst_n = 1'b0;
        fuse = 1'b1;
        fetch = 1'b1;
        eep_busy = 1'b0;
        ews = 1'b0;
        irq_en = 1'b1;
        zh = 8'h00;
        zl = 8'h00;
        r10 = 16'hFFFF;
        err_count = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        #1 arst_n = 1'b1;
        t_reset();
        t_eep();
        t_stale();
        t_erase();
        t_write();
        t_lock();
        complete_run();
    end

    // Watchdog well beyond the few hundred cycles needed
    initial
    begin
        #20000;
        err_count++;
        complete_run();
    end
endmodule : flash_self_programming_test

/* File: tb/fsp_core_model.sv */
module fsp_core_model
(
    // Clock
    input wire logic clk,
    // Control write and store instruction
    output logic ctrl_wr,
    output logic [7:0] ctrl_wdata,
    output logic store_exec
);
    timeunit 1ns;
    timeprecision 100ps;
    // Control write, then store g cycles later; g of 0 never stores
    task automatic spm(input logic [7:0] c, input int g);
        @(posedge clk);
        #1 ctrl_wr = 1'b1;
        ctrl_wdata = c;
        @(posedge clk);
        #1 ctrl_wr = 1'b0;
        if (g > 0)
        begin
            repeat (g - 1) @(posedge clk);
            #1 store_exec = 1'b1;
            @(posedge clk);
            #1 store_exec = 1'b0;
        end
    endtask : spm
    // Idle core
    initial
    begin
        ctrl_wr = 1'b0;
        ctrl_wdata = 8'h00;
        store_exec = 1'b0;
    end
endmodule : fsp_core_model

/* File: tb/fsp_sequencer_properties.sv */
module fsp_sequencer_checker
    import fsp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Core side
    input wire logic boot_vector_fuse,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic [7:0] pointer_high_byte,
    input wire logic [7:0] pointer_low_byte,
    input wire logic store_exec,
    input wire logic eeprom_busy,
    input wire logic irq_enable,
    // Outputs watched
    input wire logic [15:0] reset_vector,
    input wire logic [7:0] self_prog_ctrl_status,
    input wire logic irq,
    input wire fsp_flash_req_t flash_req
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] st;
    logic [15:0] zp;
    // Short names for status and pointer
    assign st = self_prog_ctrl_status;
    assign zp = {pointer_high_byte, pointer_low_byte};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // Boot vector, arming, refusal and the stale-command timeout
    property p_vec; boot_vector_fuse |-> reset_vector == 16'h0000; endproperty
    a_vec: assert property (p_vec) else $error("wrong application vector");
    property p_arm;
        ctrl_wr && !st[0] && !eeprom_busy && ctrl_wdata[4:0] inside {5'h01, 5'h03, 5'h05, 5'h09}
            |=> st[4:0] == $past(ctrl_wdata[4:0]);
    endproperty
    a_arm: assert property (p_arm) else $error("command bits misplaced");
    property p_eep; eeprom_busy && ctrl_wr && !st[0] |=> !st[0]; endproperty
    a_eep: assert property (p_eep) else $error("armed during eeprom write");
    property p_stale; $rose(st[0]) ##0 (!store_exec)[*4] |=> st[4:0] == 5'h00; endproperty
    a_stale: assert property (p_stale) else $error("stale command kept");
    // Array requests two cycles after the store; slack is not allowed
    property p_erase;
        store_exec && st[4:0] == 5'h03 |-> ##2 flash_req.erase && flash_req.addr[15:6] == $past(zp[15:6], 2);
    endproperty
    a_erase: assert property (p_erase) else $error("erase missing or wrong page");
    property p_lock; store_exec && st[4:0] == 5'h09 |-> ##2 flash_req.lock; endproperty
    a_lock: assert property (p_lock) else $error("lock write missing");
    property p_busy; flash_req.erase || flash_req.write |-> st[6]; endproperty
    a_busy: assert property (p_busy) else $error("busy flag low in operation");
    property p_irq; irq == (irq_enable && !st[0]); endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");
    c_erase: cover property (flash_req.erase);
    c_write: cover property (flash_req.write);
    c_lock: cover property (flash_req.lock);
endmodule : fsp_sequencer_checker

bind fsp_sequencer fsp_sequencer_checker fsp_sequencer_checker_inst (
    .clk(clk), .arst_n(arst_n), .boot_vector_fuse(boot_vector_fuse), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .pointer_high_byte(pointer_high_byte), .pointer_low_byte(pointer_low_byte),
    .store_exec(store_exec), .eeprom_busy(eeprom_busy), .irq_enable(irq_enable), .reset_vector(reset_vector),
    .self_prog_ctrl_status(self_prog_ctrl_status), .irq(irq), .flash_req(flash_req)
);
